// ==== hdl/vcap_dma_channel.sv ====
// The address map and register access over Wishbone were decided locally.
`timescale 1ns/100ps
module vcap_dma_channel
(
	input  wire logic                  clk_i,
	input  wire logic                  rst_i,
	input  wire logic                  wb_cyc_i,
	input  wire logic                  wb_stb_i,
	input  wire logic                  wb_we_i,
	input  wire logic [7:3]            wb_adr_i,
	input  wire logic [63:0]           wb_dat_i,
	output logic      [63:0]           wb_dat_o,
	output logic                       wb_ack_o,
	input  wire logic [7:0]            fifo_level_i,
	input  wire logic                  fifo_empty_i,
	input  wire logic [63:0]           fifo_data_i,
	input  wire logic                  eof_i,
	output logic                       fifo_pop_o,
	output logic                       vid_accept_o,
	output logic                       arb_req_o,
	input  wire logic                  arb_gnt_i,
	output vcap_pkg::mem_req_type      mem_req_o,
	input  wire logic                  mem_ready_i,
	input  wire logic                  mem_rvalid_i,
	input  wire logic [63:0]           mem_rdata_i,
	output logic                       eof_flag_o,
	output logic                       stop_flag_o
);

	// Software-visible state
	logic                  ctrl_en_r;     // Channel enable
	logic                  ctrl_ilv_r;    // Frame assembly mode
	logic                  stat_eof_r;    // Sticky end-of-field
	logic                  stat_stop_r;   // Sticky end of table
	logic [8:0]            line_size_r;   // Line length, doublewords minus one
	logic [8:0]            line_cnt_r;    // Doubleword within line
	logic [8:0]            page_idx_r;    // Doubleword within page
	logic [29:0]           next_ptr_r;    // Descriptor fetch pointer
	logic [29:0]           start_ptr_r;   // Frame base pointer
	logic [7:0]            thresh_r;      // Request threshold
	vcap_pkg::desc_type    desc_r [0:3];  // Descriptor cache

	// Engine state
	vcap_pkg::state_type   state_r;
	vcap_pkg::mem_req_type mem_req_r;
	logic                  pop_r;         // FIFO pop pulse
	logic                  req_r;         // Arbiter request
	logic                  accept_r;      // Video write permission
	logic                  eof_pend_r;    // Field tail in FIFO
	logic                  fetch_pend_r;  // Software-triggered fetch
	logic                  shift_pend_r;  // Software-triggered rollover
	logic                  burst_new_r;   // Next beat opens a burst
	logic                  field_r;       // Second field of frame
	logic                  beat_r;        // Second fetch beat due

	// Bus slave state
	logic                  ack_r;
	logic [63:0]           dat_r;
	logic [63:0]           rd_val;
	logic                  wr_acc;
	logic [1:0]            desc_sel;

	// Datapath helpers
	logic                  line_end;
	logic [10:0]           pidx_sum;
	logic                  roll;
	logic                  start_cond;

	assign wb_dat_o     = dat_r;
	assign wb_ack_o     = ack_r;
	assign fifo_pop_o   = pop_r;
	assign arb_req_o    = req_r;
	assign mem_req_o    = mem_req_r;
	assign vid_accept_o = accept_r;
	assign eof_flag_o   = stat_eof_r;
	assign stop_flag_o  = stat_stop_r;

	// A write lands on the edge that also sees the acknowledge
	assign wr_acc   = wb_cyc_i & wb_stb_i & wb_we_i & ack_r;
	assign desc_sel = 2'(wb_adr_i - vcap_pkg::REG_DESC0);

	// Line end clears the line counter in both modes; it skips a line only when interleaved
	assign line_end = (line_cnt_r == line_size_r);

	// Offset step: one doubleword, plus a skipped line at line end when interleaved
	always_comb
	begin
		pidx_sum = {2'h0, page_idx_r} + 11'h001;
		if (line_end && ctrl_ilv_r)
		begin
			pidx_sum = pidx_sum + {2'h0, line_size_r} + 11'h001;
		end
	end

	// Carry out of the nine bits is a page wrap, to zero when stepping by one, possibly past zero after a line skip
	assign roll = (pidx_sum[10:9] != 2'h0);

	// Start on threshold, or at once when a field has ended
	assign start_cond = ctrl_en_r && (eof_pend_r || (!fifo_empty_i && fifo_level_i >= thresh_r));

	// Register read mux; unmapped or undefined bits give zero
	always_comb
	begin
		rd_val = 64'h0;
		case (wb_adr_i)
			vcap_pkg::REG_CTRL:   rd_val[1:0] = {ctrl_ilv_r, ctrl_en_r};
			vcap_pkg::REG_STAT:   rd_val[1:0] = {stat_stop_r, stat_eof_r};
			vcap_pkg::REG_LSIZE:  rd_val[vcap_pkg::IDX_MSB:vcap_pkg::IDX_LSB] = line_size_r;
			vcap_pkg::REG_LCNT:   rd_val[vcap_pkg::IDX_MSB:vcap_pkg::IDX_LSB] = line_cnt_r;
			vcap_pkg::REG_PIDX:   rd_val[vcap_pkg::IDX_MSB:vcap_pkg::IDX_LSB] = page_idx_r;
			vcap_pkg::REG_NEXT:   rd_val[vcap_pkg::PTR_MSB:0] = next_ptr_r;
			vcap_pkg::REG_START:  rd_val[vcap_pkg::PTR_MSB:0] = start_ptr_r;
			vcap_pkg::REG_THRESH: rd_val[7:0] = thresh_r;
			vcap_pkg::REG_LEVEL:  rd_val[7:0] = fifo_level_i;
			default:
			begin
				if (wb_adr_i >= vcap_pkg::REG_DESC0 && wb_adr_i <= vcap_pkg::REG_DESC3)
				begin
					rd_val[32:0] = desc_r[desc_sel];
				end
			end
		endcase
	end

	// Wishbone slave: answer every cycle one edge after request
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			ack_r <= 1'b0;
			dat_r <= 64'h0;
		end
		else
		begin
			// whole doubleword, no length, no lanes
			ack_r <= wb_cyc_i & wb_stb_i & ~ack_r;
			if (wb_cyc_i && wb_stb_i && !ack_r)
			begin
				dat_r <= rd_val;
			end
		end
	end

	// Video side may write only while the channel is enabled
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			accept_r <= 1'b0;
		end
		else
		begin
			accept_r <= ctrl_en_r;
		end
	end

	// Registers, descriptor cache and DMA engine share one process,
	// because software and hardware both update the same state
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			ctrl_en_r    <= 1'b0;
			ctrl_ilv_r   <= 1'b0;
			stat_eof_r   <= 1'b0;
			stat_stop_r  <= 1'b0;
			line_size_r  <= 9'h000;
			line_cnt_r   <= 9'h000;
			page_idx_r   <= 9'h000;
			next_ptr_r   <= 30'h0;
			start_ptr_r  <= 30'h0;
			thresh_r     <= vcap_pkg::THRESH_RST;
			for (int k = 0; k < 4; k++)
			begin
				desc_r[k] <= '0;
			end
			state_r      <= vcap_pkg::S_IDLE;
			mem_req_r    <= '0;
			pop_r        <= 1'b0;
			req_r        <= 1'b0;
			eof_pend_r   <= 1'b0;
			fetch_pend_r <= 1'b0;
			shift_pend_r <= 1'b0;
			burst_new_r  <= 1'b0;
			field_r      <= 1'b0;
			beat_r       <= 1'b0;
		end
		else
		begin
			pop_r <= 1'b0;
			if (eof_i && ctrl_en_r)
			begin
				eof_pend_r <= 1'b1;
			end
			// Software writes; later hardware updates win
			if (wr_acc)
			begin
				case (wb_adr_i)
					vcap_pkg::REG_CTRL:
					begin
						ctrl_en_r  <= wb_dat_i[vcap_pkg::CTRL_EN_BIT];
						ctrl_ilv_r <= wb_dat_i[vcap_pkg::CTRL_ILV_BIT];
					end
					// Writing zero clears a flag, writing one keeps it
					vcap_pkg::REG_STAT:
					begin
						stat_eof_r  <= stat_eof_r & wb_dat_i[vcap_pkg::STAT_EOF_BIT];
						stat_stop_r <= stat_stop_r & wb_dat_i[vcap_pkg::STAT_STOP_BIT];
					end
					vcap_pkg::REG_LSIZE: line_size_r <= wb_dat_i[vcap_pkg::IDX_MSB:vcap_pkg::IDX_LSB];
					vcap_pkg::REG_LCNT:  line_cnt_r <= wb_dat_i[vcap_pkg::IDX_MSB:vcap_pkg::IDX_LSB];
					vcap_pkg::REG_PIDX:
					begin
						page_idx_r <= wb_dat_i[vcap_pkg::IDX_MSB:vcap_pkg::IDX_LSB];
						if (page_idx_r != 9'h000 && wb_dat_i[vcap_pkg::IDX_MSB:vcap_pkg::IDX_LSB] == 9'h000)
						begin
							shift_pend_r <= 1'b1;
						end
					end
					vcap_pkg::REG_NEXT:
					begin
						next_ptr_r   <= wb_dat_i[vcap_pkg::PTR_MSB:0];
						fetch_pend_r <= 1'b1;
						for (int k = 0; k < 4; k++)
						begin
							desc_r[k].valid <= 1'b0;
						end
					end
					vcap_pkg::REG_START:  start_ptr_r <= wb_dat_i[vcap_pkg::PTR_MSB:0];
					vcap_pkg::REG_THRESH: thresh_r <= wb_dat_i[7:0];
					default:
					begin
						// Writing a cache entry makes it valid
						if (wb_adr_i >= vcap_pkg::REG_DESC0 && wb_adr_i <= vcap_pkg::REG_DESC3)
						begin
							desc_r[desc_sel] <= {1'b1, wb_dat_i[31:0]};
						end
					end
				endcase
			end
			// DMA engine
			case (state_r)
				vcap_pkg::S_IDLE:
				begin
					// Fetches run even while disabled, so setup completes
					if (fetch_pend_r)
					begin
						req_r   <= 1'b1;
						state_r <= vcap_pkg::S_FETCH_A;
					end
					else if (shift_pend_r)
					begin
						for (int k = 0; k < 3; k++)
						begin
							desc_r[k] <= desc_r[k + 1];
						end
						desc_r[3]    <= '0;
						shift_pend_r <= 1'b0;
						state_r      <= vcap_pkg::S_CHECK;
					end
					else if (start_cond)
					begin
						req_r       <= 1'b1;
						burst_new_r <= 1'b1;
						state_r     <= vcap_pkg::S_LOAD;
					end
				end
				vcap_pkg::S_LOAD:
				begin
					if (fetch_pend_r)
					begin
						state_r <= vcap_pkg::S_FETCH_A;
					end
					else if (!ctrl_en_r)
					begin
						req_r   <= 1'b0;
						state_r <= vcap_pkg::S_IDLE;
					end
					else if (arb_gnt_i)
					begin
						if (fifo_empty_i && eof_pend_r)
						begin
							stat_eof_r  <= 1'b1;
							// A field tail arriving in this very cycle must not be lost
							eof_pend_r  <= eof_i;
							burst_new_r <= 1'b1;
							if (!ctrl_ilv_r)
							begin
								for (int k = 0; k < 3; k++)
								begin
									desc_r[k] <= desc_r[k + 1];
								end
								desc_r[3]  <= '0;
								page_idx_r <= 9'h000;
								state_r    <= vcap_pkg::S_CHECK;
							end
							else
							begin
								for (int k = 0; k < 4; k++)
								begin
									desc_r[k].valid <= 1'b0;
								end
								line_cnt_r <= 9'h000;
								field_r    <= ~field_r;
								state_r    <= vcap_pkg::S_FETCH_A;
								if (!field_r)
								begin
									next_ptr_r <= start_ptr_r;
									page_idx_r <= line_size_r + 9'h001;
								end
								else
								begin
									start_ptr_r <= next_ptr_r;
									page_idx_r  <= 9'h000;
								end
							end
						end
						else if (fifo_empty_i)
						begin
							req_r   <= 1'b0;
							state_r <= vcap_pkg::S_IDLE;
						end
						else
						begin
							mem_req_r.valid <= 1'b1;
							mem_req_r.we    <= 1'b1;
							mem_req_r.first <= burst_new_r;
							mem_req_r.addr  <= {2'h0, desc_r[0].ptr[vcap_pkg::PTR_MSB:vcap_pkg::PAGE_LSB],
								page_idx_r, 3'h0};
							mem_req_r.len   <= vcap_pkg::LEN_MAX;
							mem_req_r.data  <= fifo_data_i;
							pop_r           <= 1'b1;
							burst_new_r     <= 1'b0;
							state_r         <= vcap_pkg::S_WRITE;
						end
					end
				end
				vcap_pkg::S_WRITE:
				begin
					if (mem_ready_i)
					begin
						mem_req_r.valid <= 1'b0;
						line_cnt_r <= line_end ? 9'h000 : line_cnt_r + 9'h001;
						page_idx_r <= pidx_sum[8:0];
						if (roll)
						begin
							for (int k = 0; k < 3; k++)
							begin
								desc_r[k] <= desc_r[k + 1];
							end
							desc_r[3]   <= '0;
							burst_new_r <= 1'b1;
							state_r     <= vcap_pkg::S_CHECK;
						end
						else
						begin
							if (line_end && ctrl_ilv_r)
							begin
								burst_new_r <= 1'b1;
							end
							state_r <= vcap_pkg::S_LOAD;
						end
					end
				end
				vcap_pkg::S_CHECK:
				begin
					req_r <= 1'b1;
					if (!desc_r[0].valid)
					begin
						state_r <= vcap_pkg::S_FETCH_A;
					end
					else if (desc_r[0].stop)
					begin
						stat_stop_r <= 1'b1;
						req_r       <= 1'b0;
						state_r     <= vcap_pkg::S_HALT;
					end
					else if (desc_r[0].jump)
					begin
						next_ptr_r <= desc_r[0].ptr;
						state_r    <= vcap_pkg::S_FETCH_A;
					end
					else
					begin
						state_r <= vcap_pkg::S_LOAD;
					end
				end
				vcap_pkg::S_FETCH_A:
				begin
					req_r <= 1'b1;
					if (arb_gnt_i)
					begin
						// Two doublewords carry four descriptors
						mem_req_r.valid <= 1'b1;
						mem_req_r.we    <= 1'b0;
						mem_req_r.first <= 1'b1;
						mem_req_r.addr  <= {2'h0, next_ptr_r[vcap_pkg::PTR_MSB:4], 4'h0};
						mem_req_r.len   <= vcap_pkg::LEN_FETCH;
						mem_req_r.data  <= 64'h0;
						// A pointer written as this fetch issues is fetched again
						fetch_pend_r    <= wr_acc && (wb_adr_i == vcap_pkg::REG_NEXT);
						beat_r          <= 1'b0;
						state_r         <= vcap_pkg::S_FETCH_W;
					end
				end
				vcap_pkg::S_FETCH_W:
				begin
					if (mem_ready_i)
					begin
						mem_req_r.valid <= 1'b0;
					end
					if (mem_rvalid_i)
					begin
						// low word is the earlier descriptor
						desc_r[{beat_r, 1'b0}] <= {1'b1, mem_rdata_i[31:0]};
						desc_r[{beat_r, 1'b1}] <= {1'b1, mem_rdata_i[63:32]};
						beat_r <= 1'b1;
						if (beat_r)
						begin
							next_ptr_r <= next_ptr_r + vcap_pkg::FETCH_STEP;
							state_r    <= vcap_pkg::S_CHECK;
						end
					end
				end
				vcap_pkg::S_HALT:
				begin
					// Leaves only once software disables the channel
					if (!ctrl_en_r)
					begin
						state_r <= vcap_pkg::S_IDLE;
					end
				end
				default: state_r <= vcap_pkg::S_IDLE;
			endcase
		end
	end

	// Assertions
	a_addr_format: assert property (@(posedge clk_i) disable iff (rst_i)
		mem_req_o.valid && mem_req_o.we |-> mem_req_o.addr[2:0] == 3'h0 && mem_req_o.addr[31:30] == 2'h0
		&& mem_req_o.len == 8'hFF) else $error("bad DMA address or length");
	a_read_zero_fill: assert property (@(posedge clk_i) disable iff (rst_i)
		wb_ack_o && !wb_we_i && wb_adr_i == vcap_pkg::REG_CTRL |-> wb_dat_o[63:2] == 62'h0)
		else $error("undefined bits not zero");
	a_video_gate: assert property (@(posedge clk_i) disable iff (rst_i)
		!ctrl_en_r |=> !vid_accept_o) else $error("video accepted while disabled");
	a_page_step: assert property (@(posedge clk_i) disable iff (rst_i)
		state_r == vcap_pkg::S_WRITE && mem_ready_i && !ctrl_ilv_r && !wr_acc
		|=> page_idx_r == 9'($past(page_idx_r) + 9'h001)) else $error("page offset step wrong");
	a_stop_halt: assert property (@(posedge clk_i) disable iff (rst_i)
		state_r == vcap_pkg::S_CHECK && desc_r[0].valid && desc_r[0].stop
		|=> state_r == vcap_pkg::S_HALT && stop_flag_o && !arb_req_o) else $error("stop not honoured");
	a_ptr_invalidate: assert property (@(posedge clk_i) disable iff (rst_i)
		wr_acc && wb_adr_i == vcap_pkg::REG_NEXT |=> !desc_r[0].valid && !desc_r[3].valid
		##[0:4] state_r == vcap_pkg::S_FETCH_A) else $error("pointer write did not refetch");
	a_fetch_advance: assert property (@(posedge clk_i) disable iff (rst_i)
		state_r == vcap_pkg::S_FETCH_W && mem_rvalid_i && beat_r
		|=> next_ptr_r == $past(next_ptr_r) + 30'h0000010) else $error("fetch pointer not advanced");
	a_drain_release: assert property (@(posedge clk_i) disable iff (rst_i)
		state_r == vcap_pkg::S_LOAD && ctrl_en_r && arb_gnt_i && fifo_empty_i && !eof_pend_r && !fetch_pend_r
		|=> !arb_req_o && state_r == vcap_pkg::S_IDLE) else $error("request not dropped");
	a_req_held: assert property (@(posedge clk_i) disable iff (rst_i)
		state_r == vcap_pkg::S_WRITE |-> arb_req_o && fifo_pop_o == $past(state_r != vcap_pkg::S_WRITE))
		else $error("request dropped mid burst");
	a_eof_flag: assert property (@(posedge clk_i) disable iff (rst_i)
		state_r == vcap_pkg::S_LOAD && ctrl_en_r && arb_gnt_i && fifo_empty_i && eof_pend_r && !fetch_pend_r
		|=> eof_flag_o) else $error("end-of-field not flagged");

	c_rollover: cover property (@(posedge clk_i) disable iff (rst_i)
		state_r == vcap_pkg::S_WRITE && mem_ready_i && roll);
	c_field_end: cover property (@(posedge clk_i) disable iff (rst_i) $rose(stat_eof_r));
	c_halt: cover property (@(posedge clk_i) disable iff (rst_i) state_r == vcap_pkg::S_HALT);
	c_line_skip: cover property (@(posedge clk_i) disable iff (rst_i)
		state_r == vcap_pkg::S_WRITE && mem_ready_i && line_end && ctrl_ilv_r);

endmodule : vcap_dma_channel

// ==== hdl/vcap_pkg.sv ====
// Contract
// - Register access is one aligned 64-bit doubleword
// - Undefined register bits read back as zero
// - Two modes: field capture, interleaved frame assembly
// - Each captured field starts on fresh page; in frame assembly the second field starts one line into the first field's page
// - Descriptor: address plus valid, jump, stop flags
// - Four-entry cache, entry zero drives address
// - Page offset advances eight bytes per doubleword
// - Rollover shifts cache; invalid head fetches group
// - Rollover is any nonzero-to-zero page offset change
// - Valid stop at head halts DMA, flags
// - Fetch pointer write invalidates cache, starts fetch
// - No video accepted while disabled; threshold requests
// - Address from offset and descriptor; length maximum
// - Burst ends on empty or rollover, bus kept
// - Empty FIFO ends DMA, drops request
// - End-of-field starts DMA ignoring threshold
// - Empty after end-of-field flags and shifts once
// - Line end skips a line, keeps bus
// - First field end reloads frame base, skips line
// - Second field end updates base, refetches group
// - Line counter steps eight, clears at length
// - Valid jump at head fetches from its address
// - Fetch pointer advances sixteen per group fetch
package vcap_pkg;

	// Register indexes; byte address is index times eight
	localparam logic [4:0] REG_CTRL   = 5'h00;
	localparam logic [4:0] REG_STAT   = 5'h01;
	localparam logic [4:0] REG_LSIZE  = 5'h02;
	localparam logic [4:0] REG_LCNT   = 5'h03;
	localparam logic [4:0] REG_PIDX   = 5'h04;
	localparam logic [4:0] REG_NEXT   = 5'h05;
	localparam logic [4:0] REG_START  = 5'h06;
	localparam logic [4:0] REG_DESC0  = 5'h07;
	localparam logic [4:0] REG_DESC3  = 5'h0A;
	localparam logic [4:0] REG_THRESH = 5'h0B;
	localparam logic [4:0] REG_LEVEL  = 5'h0C;

	// Field positions
	localparam int CTRL_EN_BIT   = 0;
	localparam int CTRL_ILV_BIT  = 1;
	localparam int STAT_EOF_BIT  = 0;
	localparam int STAT_STOP_BIT = 1;
	localparam int IDX_LSB       = 3;
	localparam int IDX_MSB       = 11;
	localparam int PTR_MSB       = 29;
	localparam int PAGE_LSB      = 12;

	// Reset values and fixed codes
	localparam logic [7:0]  THRESH_RST = 8'h40;
	localparam logic [7:0]  LEN_MAX    = 8'hFF;
	localparam logic [7:0]  LEN_FETCH  = 8'h01;
	localparam logic [29:0] FETCH_STEP = 30'h00000010;

	// One cached descriptor
	typedef struct packed {
		logic        valid;
		logic        stop;
		logic        jump;
		logic [29:0] ptr;
	} desc_type;

	// One system bus request
	typedef struct packed {
		logic        valid;
		logic        we;
		logic        first;
		logic [31:0] addr;
		logic [7:0]  len;
		logic [63:0] data;
	} mem_req_type;

	typedef enum logic [2:0] {
		S_IDLE, S_LOAD, S_WRITE, S_CHECK, S_FETCH_A, S_FETCH_W, S_HALT
	} state_type;

endpackage : vcap_pkg

// ==== bench/vcap_mem_model.sv ====
`timescale 1ns/100ps
// Arbiter and memory on the far side of the channel
module vcap_mem_model
(
	input  wire logic                  clk_i,
	input  wire logic                  rst_i,
	input  wire logic                  slow_i,
	input  wire logic                  arb_req_i,
	output logic                       arb_gnt_o,
	input  wire vcap_pkg::mem_req_type mem_req_i,
	output logic                       mem_ready_o,
	output logic                       mem_rvalid_o,
	output logic [63:0]                mem_rdata_o,
	output logic [39:0]                wr_o,
	output logic [63:0]                wdat_o,
	output logic [15:0]                nwr_o
);
	logic [1:0]  wait_r;  // Slow-answer delay count
	logic [1:0]  beats_r; // Read beats still owed
	logic [31:0] fa_r;    // Address of the group being fetched

	// Descriptor word i of the group at a; entry 1 of group 200 jumps to group 400, whose head stops
	function automatic logic [31:0] word(input logic [31:0] a, input int i);
		word = 32'h0010_0000 + (a << 12) + (32'(i) << 12);
		if (a == 32'h200 && i == 1)
			word = 32'h4000_0400;
		if (a == 32'h400 && i == 0)
			word[31] = 1'b1;
	endfunction : word

	always_ff @(posedge clk_i)
		arb_gnt_o <= arb_req_i && !rst_i;

	// Beats taken only under grant; idle read data keeps changing
	always_ff @(posedge clk_i)
	begin
		mem_ready_o <= 1'b0;
		mem_rvalid_o <= 1'b0;
		mem_rdata_o <= ~mem_rdata_o;
		if (rst_i)
		begin
			wait_r <= 2'h0;
			beats_r <= 2'h0;
			nwr_o <= 16'h0000;
			mem_rdata_o <= 64'h5A5A_5A5A_5A5A_5A5A;
		end
		else if (beats_r != 2'h0)
		begin
			mem_rvalid_o <= 1'b1;
			mem_rdata_o <= (beats_r == 2'h2) ? {word(fa_r, 1), word(fa_r, 0)} : {word(fa_r, 3), word(fa_r, 2)};
			beats_r <= beats_r - 2'h1;
		end
		else if (mem_req_i.valid && arb_gnt_o && !mem_ready_o)
		begin
			wait_r <= wait_r + 2'h1;
			if (!slow_i || wait_r == 2'h3)
			begin
				mem_ready_o <= 1'b1;
				wait_r <= 2'h0;
				if (mem_req_i.we)
				begin
					wr_o <= {mem_req_i.len, mem_req_i.addr};
					wdat_o <= mem_req_i.data;
					nwr_o <= nwr_o + 16'h0001;
				end
				else
				begin
					beats_r <= 2'h2;
					fa_r <= mem_req_i.addr;
				end
			end
		end
	end
endmodule : vcap_mem_model

// ==== bench/video_capture_dma_channel_bench.sv ====
`timescale 1ns/100ps
module video_capture_dma_channel_bench;
	typedef struct packed {logic w; logic [4:0] a; logic [63:0] d; logic [63:0] e;} row_type;
	logic clk_i = 0, rst_i = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, eof_i = 0, slow = 0;
	logic [7:3] wb_adr_i = '0;
	logic [63:0] wb_dat_i = '0, wb_dat_o, rdat, fifo_data_i, mem_rdata_i, wdat;
	logic [7:0] pushed = 0, popped = 0, fifo_level_i;
	logic wb_ack_o, fifo_empty_i, fifo_pop_o, vid_accept_o, arb_req_o, arb_gnt_i;
	logic mem_ready_i, mem_rvalid_i, eof_flag_o, stop_flag_o;
	logic [39:0] wr;
	logic [15:0] nwr;
	vcap_pkg::mem_req_type mem_req_o;
	int num_errors = 0, tests_run = 0;
	// Ordinary register cases: write (if w), then read back
	row_type rows [9] = '{
		'{1'b0, vcap_pkg::REG_THRESH, 64'h0, 64'h40},
		'{1'b0, vcap_pkg::REG_DESC0, 64'h0, 64'h0},
		'{1'b0, vcap_pkg::REG_STAT, 64'h0, 64'h0},
		'{1'b1, vcap_pkg::REG_LSIZE, 64'hFFFF_FFFF_FFFF_F008, 64'h8},
		'{1'b1, vcap_pkg::REG_START, 64'hFFFF_FFFF_FFFF_FFF0, 64'h3FFF_FFF0},
		'{1'b1, vcap_pkg::REG_THRESH, 64'hFFFF_FFFF_FFFF_FF08, 64'h8},
		'{1'b1, 5'h1F, 64'hFFFF_FFFF_FFFF_FFFF, 64'h0},
		'{1'b1, vcap_pkg::REG_LEVEL, 64'hFFFF_FFFF_FFFF_FFFF, 64'h0},
		'{1'b1, vcap_pkg::REG_CTRL, 64'hFFFF_FFFF_FFFF_FFFC, 64'h0}};

	assign fifo_level_i = pushed - popped;
	assign fifo_empty_i = (pushed == popped);
	assign fifo_data_i = {32'hDA7A_0000, 24'h0, popped};

	vcap_dma_channel DUT (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_i, .wb_dat_o,
		.wb_ack_o, .fifo_level_i, .fifo_empty_i, .fifo_data_i, .eof_i, .fifo_pop_o, .vid_accept_o, .arb_req_o,
		.arb_gnt_i, .mem_req_o, .mem_ready_i, .mem_rvalid_i, .mem_rdata_i, .eof_flag_o, .stop_flag_o);
	vcap_mem_model far (.clk_i, .rst_i, .slow_i(slow), .arb_req_i(arb_req_o), .arb_gnt_o(arb_gnt_i),
		.mem_req_i(mem_req_o), .mem_ready_o(mem_ready_i), .mem_rvalid_o(mem_rvalid_i),
		.mem_rdata_o(mem_rdata_i), .wr_o(wr), .wdat_o(wdat), .nwr_o(nwr));

	always #5 clk_i = ~clk_i;
	// Stand-in FIFO; emptied while the channel is disabled
	always @(posedge clk_i)
		popped <= vid_accept_o ? popped + 8'(fifo_pop_o) : pushed;

	task end_of_test;
		$display("errors %0d, checks %0d", num_errors, tests_run);
		if (num_errors == 0 && tests_run > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : end_of_test

	task chk(input string n, input logic [63:0] s, input logic [63:0] e);
		tests_run++;
		if (s !== e)
		begin
			num_errors++;
			$display("unexpected %s expected %h seen %h", n, e, s);
		end
	endtask : chk

	// Classic single cycle, held until ack is sampled
	task wb(input logic w, input logic [4:0] a, input logic [63:0] d);
		int n;
		@(posedge clk_i);
		{wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, w, a, d};
		n = 0;
		do
		begin
			@(posedge clk_i);
			n++;
		end
		while (wb_ack_o !== 1'b1 && n < 50);
		rdat = wb_dat_o;
		{wb_cyc_i, wb_stb_i} <= 2'b00;
		if (n >= 50) begin num_errors++; end_of_test; end
		// One idle edge lets a landed write show before anyone looks
		@(posedge clk_i);
	endtask : wb

	task rchk(input string n, input logic [4:0] a, input logic [63:0] e);
		wb(1'b0, a, 64'h0);
		chk(n, rdat, e);
	endtask : rchk

	// Video words plus an optional end-of-field pulse
	task push(input logic [7:0] k, input logic e);
		@(posedge clk_i);
		pushed <= pushed + k;
		eof_i <= e;
		@(posedge clk_i);
		eof_i <= 1'b0;
	endtask : push

	// Request rises within 20 cycles if at all, then must drop
	task wait_dma;
		int n;
		n = 0;
		while (arb_req_o !== 1'b1 && n < 20) begin @(posedge clk_i); n++; end
		n = 0;
		while (arb_req_o !== 1'b0 && n < 4000) begin @(posedge clk_i); n++; end
		if (n >= 4000) begin num_errors++; end_of_test; end
		repeat (2) @(posedge clk_i);
	endtask : wait_dma

	initial
	begin
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		foreach (rows[i])
		begin
			if (rows[i].w) wb(1'b1, rows[i].a, rows[i].d);
			rchk("reg", rows[i].a, rows[i].e);
		end
		chk("accept off", vid_accept_o, 1'b0);
		wb(1'b1, vcap_pkg::REG_PIDX, 64'h0);
		wb(1'b1, vcap_pkg::REG_NEXT, 64'h100);
		wait_dma;
		rchk("next", vcap_pkg::REG_NEXT, 64'h110);
		rchk("desc0", vcap_pkg::REG_DESC0, 64'h1_0020_0000);
		wb(1'b1, vcap_pkg::REG_CTRL, 64'h1);
		repeat (2) @(posedge clk_i);
		chk("accept on", vid_accept_o, 1'b1);
		push(8'd4, 1'b0);
		repeat (20) @(posedge clk_i);
		chk("req below level", arb_req_o, 1'b0);
		push(8'd0, 1'b1);
		wait_dma;
		chk("write addr", wr, {8'hFF, 32'h0020_0018});
		chk("writes", nwr, 16'd4);
		chk("word", wdat, {32'hDA7A_0000, 32'h3});
		chk("eof flag", eof_flag_o, 1'b1);
		rchk("field shift", vcap_pkg::REG_DESC0, 64'h1_0020_1000);
		rchk("index", vcap_pkg::REG_PIDX, 64'h0);
		wb(1'b1, vcap_pkg::REG_STAT, 64'h0);
		chk("eof cleared", eof_flag_o, 1'b0);
		// Page end in mid-burst, with a slow memory
		slow <= 1'b1;
		wb(1'b1, vcap_pkg::REG_PIDX, 64'hFF0);
		push(8'd8, 1'b0);
		wait_dma;
		chk("rollover addr", wr, {8'hFF, 32'h0020_2028});
		chk("writes", nwr, 16'd12);
		// Software rollovers: shift, then fetch on invalid head
		wb(1'b1, vcap_pkg::REG_PIDX, 64'h8);
		wb(1'b1, vcap_pkg::REG_PIDX, 64'h0);
		rchk("sw shift", vcap_pkg::REG_DESC0, 64'h1_0020_3000);
		wb(1'b1, vcap_pkg::REG_PIDX, 64'h8);
		wb(1'b1, vcap_pkg::REG_PIDX, 64'h0);
		wait_dma;
		rchk("refetch", vcap_pkg::REG_DESC0, 64'h1_0021_0000);
		rchk("next", vcap_pkg::REG_NEXT, 64'h120);
		// Jump entry reaches the head, the group it jumps to holds a stop entry at its head
		// pointers stay quad-word aligned
		wb(1'b1, vcap_pkg::REG_NEXT, 64'h200);
		wait_dma;
		rchk("desc0", vcap_pkg::REG_DESC0, 64'h1_0030_0000);
		wb(1'b1, vcap_pkg::REG_PIDX, 64'h8);
		wb(1'b1, vcap_pkg::REG_PIDX, 64'h0);
		repeat (20) @(posedge clk_i);
		chk("stop flag", stop_flag_o, 1'b1);
		rchk("jump", vcap_pkg::REG_NEXT, 64'h410);
		push(8'd8, 1'b0);
		repeat (30) @(posedge clk_i);
		chk("halted", nwr, 16'd12);
		wb(1'b1, vcap_pkg::REG_CTRL, 64'h0);
		wb(1'b1, vcap_pkg::REG_STAT, 64'h0);
		chk("stop cleared", stop_flag_o, 1'b0);
		// Frame assembly with two-doubleword lines
		// counters, base, then pointer
		wb(1'b1, vcap_pkg::REG_PIDX, 64'h0);
		wb(1'b1, vcap_pkg::REG_LCNT, 64'h0);
		wb(1'b1, vcap_pkg::REG_START, 64'h100);
		wb(1'b1, vcap_pkg::REG_NEXT, 64'h100);
		wait_dma;
		wb(1'b1, vcap_pkg::REG_CTRL, 64'h3);
		repeat (2) @(posedge clk_i);
		push(8'd4, 1'b1);
		wait_dma;
		wait_dma;
		chk("line skip", wr, {8'hFF, 32'h0020_0028});
		rchk("line count", vcap_pkg::REG_LCNT, 64'h0);
		rchk("second field", vcap_pkg::REG_PIDX, 64'h10);
		rchk("base reload", vcap_pkg::REG_NEXT, 64'h110);
		// Second field fills the skipped lines, then a new frame base
		push(8'd4, 1'b1);
		wait_dma;
		chk("second field addr", wr, {8'hFF, 32'h0020_0038});
		rchk("new base", vcap_pkg::REG_START, 64'h110);
		rchk("new frame", vcap_pkg::REG_DESC0, 64'h1_0021_0000);
		// Mid-run reset clears flags, request, gate and cache
		rst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		chk("reset outputs", {eof_flag_o, stop_flag_o, arb_req_o, vid_accept_o}, 64'h0);
		rchk("reset thresh", vcap_pkg::REG_THRESH, 64'h40);
		rchk("reset desc0", vcap_pkg::REG_DESC0, 64'h0);
		end_of_test;
	end
endmodule : video_capture_dma_channel_bench
